// *** hdl/sesr_defs.vh ***
// constants for the standard event status register block
//
// Function
// - clear-status empties event register and queues; enable mask is kept.
// - writable 8-bit enable mask, range 0 to 255, default 0, readable.
// - bits 1 and 6 of event register and mask always read zero.
// - bit 7 set when power cycled since last read or clear.
// - bit 5 command error, bit 4 execution error, bit 3 device error.
// - bit 2 query error on empty read, unread response, or both buffers full.
// - bit 0 set once all commands through operation-complete have executed.
// - queries return the unsigned sum of weights of set bits.
// - event register query returns contents and clears the register.
// - identification query returns maker, model, serial, version fields.
// - after operation-complete command, bit 0 sets when current scan ends.
// - operation-complete query returns 1 if operation finished, else 0.
// - power-on-clear setting is writable and readable, selects enable clearing.
// - setting defaults to 1; when 1 enable registers zero at power-up only.
`ifndef SESR_DEFS_VH
`define SESR_DEFS_VH
`define SESR_BIT_OPC 0
`define SESR_BIT_QRY 2
`define SESR_BIT_DEV 3
`define SESR_BIT_EXE 4
`define SESR_BIT_CMD 5
`define SESR_BIT_PON 7
`define SESR_USED_MASK 8'hbd
`define SESR_ENA_RESET 8'h00
`define SESR_EVT_RESET 8'h80
`define SESR_PSC_RESET 1'h1
`define SESR_ZERO8 8'h00
`define SESR_ONE8 8'h01
`define SESR_ID_CHARS 4
`define SESR_ID_IDX_W 2
`define SESR_ID_MAKER 2'h0
`define SESR_ID_MODEL 2'h1
`define SESR_ID_SERIAL 2'h2
`define SESR_ID_LAST 2'h3
`endif

// *** hdl/sesr_regs.v ***
// standard event status register bank with enable mask and opc handling
`default_nettype none
`include "sesr_defs.vh"
module sesr_regs #(
   // arbitrary neutral identification bytes: maker, model, serial, version
   parameter [7:0] ID_MAKER = 8'h41,
   parameter [7:0] ID_MODEL = 8'h42,
   parameter [7:0] ID_SERIAL = 8'h43,
   parameter [7:0] ID_VERSION = 8'h44
) (
   input wire clk,
   input wire rst_b,
   input wire cls_cmd,
   input wire ese_wr,
   input wire [7:0] ese_wdata,
   input wire ese_rd,
   input wire esr_rd,
   input wire psc_wr,
   input wire psc_wdata,
   input wire psc_rd,
   input wire opc_cmd,
   input wire opc_qry,
   input wire idn_qry,
   input wire scan_busy,
   input wire cmd_err,
   input wire exe_err,
   input wire dev_err,
   input wire rd_empty_out,
   input wire new_line_unread,
   input wire bufs_full,
   output reg [7:0] resp_data,
   output reg resp_valid,
   output reg resp_last,
   output reg [7:0] event_status,
   output reg [7:0] enable_mask,
   output reg psc_setting,
   output reg err_queue_clr
);
   // *****************************
   // state
   // *****************************
   reg [7:0] event_reg;
   reg [7:0] event_next;
   reg [7:0] ena_reg;
   reg psc_reg;
   reg opc_armed_reg;
   reg resp_state_reg;
   reg resp_state_next;
   reg [`SESR_ID_IDX_W-1:0] idn_idx_reg;
   reg pwr_done_reg;

   function [7:0] id_char;
      input [`SESR_ID_IDX_W-1:0] idx;
      begin
         case (idx)
            `SESR_ID_MAKER: id_char = ID_MAKER;
            `SESR_ID_MODEL: id_char = ID_MODEL;
            `SESR_ID_SERIAL: id_char = ID_SERIAL;
            default: id_char = ID_VERSION;
         endcase
      end
   endfunction

   // *****************************
   // query acceptance
   // *****************************
   // while the identity answer streams every other query is refused; a refused
   // event read must not clear the register, or its events would be lost
   localparam RESP_IDLE = 1'b0;
   localparam RESP_IDENT = 1'b1;

   wire resp_free = (resp_state_reg == RESP_IDLE);
   wire take_esr = resp_free & esr_rd;
   wire take_ese = resp_free & ~esr_rd & ese_rd;
   wire take_psc = resp_free & ~esr_rd & ~ese_rd & psc_rd;
   wire take_opc = resp_free & ~esr_rd & ~ese_rd & ~psc_rd & opc_qry;
   wire take_idn = resp_free & ~esr_rd & ~ese_rd & ~psc_rd & ~opc_qry & idn_qry;
   // opc answer follows scan_busy of the strobe cycle, not a latched copy
   wire take_one = take_esr | take_ese | take_psc | take_opc;
   wire ident_end = (idn_idx_reg == `SESR_ID_LAST);

   // one-byte answers share one formatting path
   // priority esr, then mask, then setting, else operation complete
   function [7:0] short_answer;
      input sel_esr;
      input sel_ese;
      input sel_psc;
      input [7:0] evt;
      input [7:0] ena;
      input psc;
      input busy;
      begin
         if (sel_esr) short_answer = evt;
         else if (sel_ese) short_answer = ena;
         else if (sel_psc) short_answer = {7'h00, psc};
         else short_answer = busy ? `SESR_ZERO8 : `SESR_ONE8;
      end
   endfunction

   // *****************************
   // event register next value
   // *****************************
   wire scan_done = opc_armed_reg & ~scan_busy;
   // any of the three buffer faults counts as one query error
   wire query_fault = rd_empty_out | new_line_unread | bufs_full;
   wire pwr_clear = ~pwr_done_reg & psc_reg;
   always @* begin
      event_next = event_reg;
      if (take_esr || cls_cmd) begin
         event_next = `SESR_ZERO8;
      end
      // sets applied after the clear so a same-cycle event is not lost
      if (cmd_err) event_next[`SESR_BIT_CMD] = 1'b1;
      if (exe_err) event_next[`SESR_BIT_EXE] = 1'b1;
      if (dev_err) event_next[`SESR_BIT_DEV] = 1'b1;
      if (query_fault) begin
         event_next[`SESR_BIT_QRY] = 1'b1;
      end
      if (scan_done) event_next[`SESR_BIT_OPC] = 1'b1;
      event_next = event_next & `SESR_USED_MASK;
   end

   // *****************************
   // registers
   // *****************************
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         event_reg <= `SESR_EVT_RESET;
         ena_reg <= `SESR_ENA_RESET;
         psc_reg <= `SESR_PSC_RESET;
         opc_armed_reg <= 1'b0;
         pwr_done_reg <= 1'b0;
      end else begin
         event_reg <= event_next;
         pwr_done_reg <= 1'b1;
         // without a retention store the mask powers up at 0 either way;
         // psc only decides whether clearing is asserted at power-up
         if (pwr_clear) ena_reg <= `SESR_ENA_RESET;
         else if (ese_wr) ena_reg <= ese_wdata & `SESR_USED_MASK;
         if (psc_wr) psc_reg <= psc_wdata;
         if (cls_cmd) opc_armed_reg <= 1'b0;
         else if (opc_cmd) opc_armed_reg <= 1'b1;
         else if (scan_done) opc_armed_reg <= 1'b0;
      end
   end

   // *****************************
   // query responses
   // *****************************
   // the identity answer always runs its four bytes to the end
   always @* begin
      resp_state_next = resp_state_reg;
      case (resp_state_reg)
         RESP_IDLE: begin
            if (take_idn) resp_state_next = RESP_IDENT;
         end
         RESP_IDENT: begin
            if (ident_end) resp_state_next = RESP_IDLE;
         end
         default: begin
            resp_state_next = RESP_IDLE;
         end
      endcase
   end

   // a refused query gets no answer at all; the host has to ask again
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         resp_state_reg <= RESP_IDLE;
         idn_idx_reg <= {`SESR_ID_IDX_W{1'b0}};
         resp_data <= `SESR_ZERO8;
         resp_valid <= 1'b0;
         resp_last <= 1'b0;
      end else begin
         resp_state_reg <= resp_state_next;
         resp_valid <= 1'b0;
         resp_last <= 1'b0;
         case (resp_state_reg)
            RESP_IDLE: begin
               // index is parked at the first field while idle
               idn_idx_reg <= {`SESR_ID_IDX_W{1'b0}};
               if (take_one) begin
                  resp_data <= short_answer(take_esr, take_ese, take_psc,
                     event_reg, ena_reg, psc_reg,
                     scan_busy);
                  resp_valid <= 1'b1;
                  resp_last <= 1'b1;
               end
            end
            RESP_IDENT: begin
               resp_data <= id_char(idn_idx_reg);
               resp_valid <= 1'b1;
               resp_last <= ident_end;
               idn_idx_reg <= idn_idx_reg + 1'b1;
            end
            default: begin
               idn_idx_reg <= {`SESR_ID_IDX_W{1'b0}};
            end
         endcase
      end
   end

   // *****************************
   // status mirrors
   // *****************************
   // mirrors trail the registers by one cycle so every output leaves a flop
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         event_status <= `SESR_ZERO8;
         enable_mask <= `SESR_ZERO8;
         psc_setting <= 1'b0;
         err_queue_clr <= 1'b0;
      end else begin
         event_status <= event_reg;
         enable_mask <= ena_reg;
         psc_setting <= psc_reg;
         err_queue_clr <= cls_cmd;
      end
   end
endmodule
`default_nettype wire

// *** tb/sesr_checker.sv ***
// concurrent checks on the ports of the event status block
`default_nettype none
module sesr_checker (
   input wire logic clk, rst_b, cls_cmd, ese_wr, ese_rd, esr_rd, psc_rd, opc_qry, idn_qry,
   input wire logic cmd_err, rd_empty_out, new_line_unread, bufs_full,
   input wire logic resp_valid, resp_last, err_queue_clr,
   input wire logic [7:0] ese_wdata, event_status, enable_mask
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_burst;
      (resp_valid && !resp_last) [*3] ##1 (resp_valid && resp_last);
   endsequence
   // a query in the idle gap of an identity answer is refused
   a_esr_answer: assert property (
      esr_rd && !resp_valid && !$past(idn_qry) |=> resp_valid && resp_last)
      else $error("event read not answered");
   a_cls_keeps: assert property (
      cls_cmd && !ese_wr && !$past(ese_wr) |=> err_queue_clr && $stable(enable_mask))
      else $error("clear status wrong");
   a_unused_zero: assert property (((event_status | enable_mask) & 8'h42) == 8'h00)
      else $error("unused bit set");
   a_cmd_bit: assert property (cmd_err |=> ##1 event_status[5])
      else $error("command error bit missing");
   a_query_bit: assert property (
      rd_empty_out || new_line_unread || bufs_full |=> ##1 event_status[2])
      else $error("query error bit missing");
   a_bit_latch: assert property (
      event_status[5] && !$past(esr_rd) && !$past(cls_cmd) |=> event_status[5])
      else $error("event bit lost");
   a_mask_write: assert property (ese_wr |=> ##1 enable_mask == ($past(ese_wdata, 2) & 8'hbd))
      else $error("mask write wrong");
   a_ident_burst: assert property (
      idn_qry && !$past(idn_qry) && !(resp_valid || esr_rd || ese_rd || psc_rd || opc_qry)
      |-> ##2 s_burst)
      else $error("identity answer malformed");
endmodule
`default_nettype wire

// *** tb/sesr_host.sv ***
// response collector standing for the remote host
`default_nettype none
module sesr_host (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic resp_valid,
   input wire logic [7:0] resp_data,
   output logic [31:0] seq,
   output logic [7:0] n_resp
);
   timeunit 1ns;
   timeprecision 1ns;
   // keeps four bytes so the field order of a long answer can be judged
   always @(posedge clk or negedge rst_b)
      if (!rst_b) begin
         seq <= 32'h0;
         n_resp <= 8'h00;
      end else if (resp_valid) begin
         seq <= {seq[23:0], resp_data};
         n_resp <= n_resp + 8'h01;
      end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the standard event status block
`default_nettype none
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
   $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_b = 0, scan_busy = 0;
   logic [14:0] s = 0;
   logic [7:0] w = 0;
   logic [31:0] seq;
   logic [7:0] n_resp, n_before;
   int error_cnt = 0, checks_done = 0, i;
   wire cls_cmd, ese_wr, ese_rd, esr_rd, psc_wr, psc_rd, opc_cmd, opc_qry, idn_qry, cmd_err;
   wire exe_err, dev_err, rd_empty_out, new_line_unread, bufs_full, resp_valid, resp_last;
   wire psc_setting, err_queue_clr;
   wire psc_wdata = w[0];
   wire [7:0] ese_wdata = w;
   wire [7:0] resp_data, event_status, enable_mask;
   assign {bufs_full, new_line_unread, rd_empty_out, dev_err, exe_err, cmd_err, idn_qry,
      opc_qry, opc_cmd, psc_rd, psc_wr, esr_rd, ese_rd, ese_wr, cls_cmd} = s;
   sesr_regs i_sesr_regs (.clk(clk), .rst_b(rst_b), .cls_cmd(cls_cmd), .ese_wr(ese_wr),
      .ese_wdata(ese_wdata), .ese_rd(ese_rd), .esr_rd(esr_rd), .psc_wr(psc_wr),
      .psc_wdata(psc_wdata), .psc_rd(psc_rd), .opc_cmd(opc_cmd), .opc_qry(opc_qry),
      .idn_qry(idn_qry), .scan_busy(scan_busy), .cmd_err(cmd_err), .exe_err(exe_err),
      .dev_err(dev_err), .rd_empty_out(rd_empty_out), .new_line_unread(new_line_unread),
      .bufs_full(bufs_full), .resp_data(resp_data), .resp_valid(resp_valid),
      .resp_last(resp_last), .event_status(event_status), .enable_mask(enable_mask),
      .psc_setting(psc_setting), .err_queue_clr(err_queue_clr));
   sesr_host i_sesr_host (.clk(clk), .rst_b(rst_b), .resp_valid(resp_valid),
      .resp_data(resp_data), .seq(seq), .n_resp(n_resp));
   initial forever #5 clk = ~clk;
   // one strobe pulse, then room for the longest answer to land
   task go(input logic [14:0] v, input logic [7:0] d);
      @(posedge clk) s <= v;
      w <= d;
      @(posedge clk) s <= 15'h0;
      repeat (8) @(posedge clk);
   endtask
   task ask(input logic [14:0] v, input logic [7:0] want);
      n_before = n_resp;
      go(v, 8'h00);
      `CK(seq[7:0], want)
      `CK(n_resp, n_before + 8'h01)
   endtask
   task t_errors;
      for (i = 9; i < 15; i++) begin
         go(15'h1 << i, 8'h00);
         repeat (20) @(posedge clk);
         ask(15'h8, i < 12 ? 8'h20 >> (i - 9) : 8'h04);
      end
   endtask
   task t_mask;
      go(15'h2, 8'hff);
      ask(15'h4, 8'hbd);
      go(15'h2, 8'h90);
      go(15'h200, 8'h00);
      go(15'h1, 8'h00);
      ask(15'h4, 8'h90);
      ask(15'h8, 8'h00);
   endtask
   task t_opc;
      scan_busy <= 1'b1;
      go(15'h40, 8'h00);
      ask(15'h80, 8'h00);
      ask(15'h8, 8'h00);
      @(posedge clk) scan_busy <= 1'b0;
      for (i = 0; i < 50 && event_status !== 8'h01; i++) @(negedge clk);
      if (i == 50) error_cnt++;
      if (i == 50) final_report;
      ask(15'h80, 8'h01);
      ask(15'h8, 8'h01);
   endtask
   task t_setting;
      go(15'h10, 8'h00);
      ask(15'h20, 8'h00);
      `CK(psc_setting, 1'b0)
      go(15'h10, 8'h01);
      ask(15'h20, 8'h01);
      `CK(psc_setting, 1'b1)
      go(15'h100, 8'h00);
      `CK(seq, 32'h41424344)
   endtask
   task final_report;
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      ask(15'h8, 8'h80);
      ask(15'h8, 8'h00);
      ask(15'h4, 8'h00);
      ask(15'h20, 8'h01);
      t_errors;
      t_mask;
      t_opc;
      t_setting;
      final_report;
   end
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      final_report;
   end
endmodule
bind sesr_regs sesr_checker i_sesr_checker (.clk(clk), .rst_b(rst_b), .cls_cmd(cls_cmd),
   .ese_wr(ese_wr), .ese_rd(ese_rd), .esr_rd(esr_rd), .psc_rd(psc_rd), .opc_qry(opc_qry),
   .idn_qry(idn_qry), .cmd_err(cmd_err), .rd_empty_out(rd_empty_out),
   .new_line_unread(new_line_unread), .bufs_full(bufs_full), .resp_valid(resp_valid),
   .resp_last(resp_last), .err_queue_clr(err_queue_clr), .ese_wdata(ese_wdata),
   .event_status(event_status), .enable_mask(enable_mask));
`default_nettype wire
